// File: src/isr_seq.sv
/*
 * Master stop and repeated-start sequencer with collision detection.
 * Assumes open-drain pins resolved outside; software pulses start requests and buffer writes.
 */
`default_nettype none
`include "isr_params.svh"
module isr_seq #(
    parameter int RW = `ISR_RELOAD_W
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [RW-1:0] baud_reload_value_i,
    input wire logic ninth_fall_i,
    input wire logic stop_start_i,
    input wire logic rstart_start_i,
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_wdata_i,
    input wire logic flags_clr_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output logic stop_seq_enable_o,
    output logic stop_detected_o,
    output logic port_irq_flag_o,
    output logic write_collision_o,
    output logic bus_collision_o,
    output logic [7:0] shift_buffer_o
);
    isr_pkg::isr_state_e st_q, st_d;
    logic [RW-1:0] cnt_q, cnt_d;
    logic scl_s, sda_s, scl_prev_q, seen_low_q;
    logic scl_oe_q, sda_oe_q, stop_en_q, stopdet_q, irq_q, wr_col_q, bcol_q;
    logic [7:0] buf_q;

    isr_pin_sync u_scl (.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_i(scl_i), .level_o(scl_s));
    isr_pin_sync u_sda (.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_i(sda_i), .level_o(sda_s));

    function automatic logic expired(input logic [RW-1:0] c);
        return c == '0;
    endfunction

    wire tmo = expired(cnt_q);
    wire scl_rise = scl_s && !scl_prev_q;
    wire scl_fall = !scl_s && scl_prev_q;
    wire stop_busy = (st_q >= isr_pkg::ST_P_SDA_LOW) && (st_q <= isr_pkg::ST_P_DONE);
    wire in_rs = (st_q >= isr_pkg::ST_R_SDA_REL);
    // Collision cases only apply once SCL has been released by us.
    wire col_sda = (st_q == isr_pkg::ST_R_SCL_REL) && scl_rise && !sda_s;
    wire col_scl = (st_q == isr_pkg::ST_R_SDA_CHK) && scl_fall;
    wire collide = col_sda || col_scl;
    wire wr_col_set = buf_wr_i && stop_busy;
    wire stop_seen = (st_q == isr_pkg::ST_P_SDA_REL) && sda_s && scl_s && seen_low_q;

    always_comb
    begin
        st_d = st_q;
        cnt_d = tmo ? cnt_q : cnt_q - 1'b1;
        case (st_q)
            isr_pkg::ST_IDLE:
                if (ninth_fall_i)
                    st_d = isr_pkg::ST_HOLD;
            isr_pkg::ST_HOLD:
                if (stop_start_i)
                    st_d = isr_pkg::ST_P_SDA_LOW;
                else if (rstart_start_i)
                begin
                    st_d = isr_pkg::ST_R_SDA_REL;
                    cnt_d = baud_reload_value_i;
                end
            isr_pkg::ST_P_SDA_LOW:
                if (!sda_s)
                begin
                    st_d = isr_pkg::ST_P_COUNT;
                    cnt_d = baud_reload_value_i;
                end
            isr_pkg::ST_P_COUNT:
                if (tmo)
                begin
                    st_d = isr_pkg::ST_P_SCL_HIGH;
                    cnt_d = baud_reload_value_i;
                end
            isr_pkg::ST_P_SCL_HIGH:
                if (tmo)
                    st_d = isr_pkg::ST_P_SDA_REL;
            isr_pkg::ST_P_SDA_REL:
                if (stop_seen)
                begin
                    st_d = isr_pkg::ST_P_DONE;
                    cnt_d = baud_reload_value_i;
                end
            isr_pkg::ST_P_DONE:
                if (tmo)
                    st_d = isr_pkg::ST_IDLE;
            isr_pkg::ST_R_SDA_REL:
                if (tmo)
                    st_d = isr_pkg::ST_R_SCL_REL;
            isr_pkg::ST_R_SCL_REL:
                if (collide)
                    st_d = isr_pkg::ST_IDLE;
                else if (scl_s)
                begin
                    st_d = isr_pkg::ST_R_SDA_CHK;
                    cnt_d = baud_reload_value_i;
                end
            isr_pkg::ST_R_SDA_CHK:
                if (collide)
                    st_d = isr_pkg::ST_IDLE;
                else if (tmo && scl_s && sda_s)
                begin
                    st_d = isr_pkg::ST_R_SDA_LOW;
                    cnt_d = baud_reload_value_i;
                end
                else if (tmo)
                    st_d = isr_pkg::ST_IDLE;
            isr_pkg::ST_R_SDA_LOW:
                if (tmo)
                    st_d = isr_pkg::ST_HOLD;
            default:
                st_d = isr_pkg::ST_IDLE;
        endcase
    end

    // Open-drain drive: oe high pulls the line low.
    wire scl_drive_d = (st_d == isr_pkg::ST_HOLD) || (st_d == isr_pkg::ST_P_SDA_LOW) ||
        (st_d == isr_pkg::ST_P_COUNT) || (st_d == isr_pkg::ST_R_SDA_REL);
    // After a repeated start SDA stays low under the held clock. Letting it go on the edge that pulls
    // SCL low could show a rising SDA while SCL is still high, which every slave would take as a Stop.
    wire rs_keep = (st_d == isr_pkg::ST_HOLD) && ((st_q == isr_pkg::ST_R_SDA_LOW) ||
        (st_q == isr_pkg::ST_HOLD && sda_oe_q));
    wire sda_drive_d = (st_d >= isr_pkg::ST_P_SDA_LOW && st_d <= isr_pkg::ST_P_SCL_HIGH) ||
        (st_d == isr_pkg::ST_R_SDA_LOW) || rs_keep;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_q <= isr_pkg::ST_IDLE;
            cnt_q <= '0;
            scl_prev_q <= 1'b1;
            seen_low_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            scl_prev_q <= scl_s;
            seen_low_q <= (st_d == isr_pkg::ST_IDLE) ? 1'b0 : (seen_low_q || !scl_s);
            scl_oe_q <= scl_drive_d;
            sda_oe_q <= sda_drive_d;
        end
    end

    // Flags: hardware set beats software clear in the same cycle.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stop_en_q <= 1'b0;
            stopdet_q <= 1'b0;
            irq_q <= 1'b0;
            wr_col_q <= 1'b0;
            bcol_q <= 1'b0;
            buf_q <= 8'h00;
        end
        else
        begin
            if (st_q == isr_pkg::ST_HOLD && stop_start_i)
                stop_en_q <= 1'b1;
            else if (st_q == isr_pkg::ST_P_DONE && tmo)
                stop_en_q <= 1'b0;
            stopdet_q <= stop_seen || (stopdet_q && !flags_clr_i);
            irq_q <= (st_q == isr_pkg::ST_P_DONE && tmo) || (irq_q && !flags_clr_i);
            wr_col_q <= wr_col_set || (wr_col_q && !flags_clr_i);
            bcol_q <= collide || (bcol_q && !flags_clr_i);
            if (buf_wr_i && !stop_busy)
                buf_q <= buf_wdata_i;
        end
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;
    assign stop_seq_enable_o = stop_en_q;
    assign stop_detected_o = stopdet_q;
    assign port_irq_flag_o = irq_q;
    assign write_collision_o = wr_col_q;
    assign bus_collision_o = bcol_q;
    assign shift_buffer_o = buf_q;

    a_wr_col_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        buf_wr_i && stop_busy |=> write_collision_o && $stable(shift_buffer_o))
        else $error("write collision not flagged");
    a_sda_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_HOLD && stop_start_i |=> sda_oe_o && scl_oe_o)
        else $error("stop did not pull SDA low");
    a_scl_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_IDLE && ninth_fall_i |=> scl_oe_o)
        else $error("SCL not held after ninth clock");
    a_scl_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_P_COUNT && tmo |=> !scl_oe_o && sda_oe_o)
        else $error("SCL not released before SDA");
    a_reload_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_P_SDA_LOW && !sda_s |=> cnt_q == baud_reload_value_i)
        else $error("baud counter not reloaded");
    a_stop_det: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        stop_seen |=> stop_detected_o && stop_seq_enable_o)
        else $error("stop detect not set");
    a_pen_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_P_DONE && tmo |=> !stop_seq_enable_o && port_irq_flag_o)
        else $error("enable not cleared or irq missing");
    a_col_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        collide |=> bus_collision_o && !scl_oe_o && !sda_oe_o && st_q == isr_pkg::ST_IDLE)
        else $error("collision not handled");
    a_rs_sda_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_R_SDA_CHK && tmo && scl_s && sda_s && !collide |=> sda_oe_o)
        else $error("repeated start SDA not driven");
    a_rs_done: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_R_SDA_LOW && tmo |=> scl_oe_o && sda_oe_o)
        else $error("repeated start not completed");

    c_stop_done: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_P_DONE && tmo);
    c_rs_done: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        st_q == isr_pkg::ST_R_SDA_LOW && tmo);
    c_col: cover property (@(posedge clk_i) disable iff (!rst_b_i) collide);
    c_rs_sda_fall: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        in_rs && !sda_oe_q && $fell(sda_s) && !collide);
endmodule // isr_seq
`default_nettype wire

// File: common/isr_params.svh
/*
 * Constants for the stop and repeated-start sequencer: reload width and synchroniser depth.
 * Assumes it is included by bare name from the design files.
 */
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
`define ISR_RELOAD_W 8
`define ISR_RELOAD_RST 8'h04
`define ISR_SYNC_STAGES 3
`endif

// File: common/isr_pkg.sv
/*
 * Types shared by the sequencer files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package isr_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_HOLD,
        ST_P_SDA_LOW,
        ST_P_COUNT,
        ST_P_SCL_HIGH,
        ST_P_SDA_REL,
        ST_P_DONE,
        ST_R_SDA_REL,
        ST_R_SCL_REL,
        ST_R_SDA_CHK,
        ST_R_SDA_LOW
    } isr_state_e;
endpackage
`default_nettype wire

// File: src/isr_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one bus line.
 * Assumes the input is asynchronous to clk_i and idles high.
 */
`default_nettype none
`include "isr_params.svh"
module isr_pin_sync (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    output logic level_o
);
    logic [`ISR_SYNC_STAGES-1:0] sh_q;
    logic level_q;
    wire agree = (sh_q[1] == sh_q[2]);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sh_q <= '1;
            level_q <= 1'b1;
        end
        else
        begin
            sh_q <= {sh_q[1:0], pin_i};
            if (agree)
                level_q <= sh_q[2];
        end
    end

    assign level_o = level_q;
endmodule // isr_pin_sync
`default_nettype wire

// File: bench/isr_bus_model.sv
/* Far side of the bus: pull-ups, a slow slave and competing masters.
   Assumes the bench sets a non-zero mode only while the sequencer holds SCL low. */
`default_nettype none
module isr_bus_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] mode_i,
    input wire logic scl_oe_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt_q;
    logic hit_q;
    logic run;
    // A released line floats high; the short stretch holds SCL low for three cycles after release.
    assign scl_o = !(scl_oe_i || (mode_i == 3'h3 && cnt_q < 5'h03) || (mode_i == 3'h2 && hit_q));
    assign sda_o = !(sda_oe_i || mode_i == 3'h1 || (mode_i == 3'h4 && hit_q));
    assign run = (mode_i == 3'h3) ? !scl_oe_i : scl_o;
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= 5'h00;
            hit_q <= 1'b0;
        end
        else
        begin
            cnt_q <= !run ? 5'h00 : (cnt_q == 5'h1F ? cnt_q : cnt_q + 5'h01);
            hit_q <= (mode_i == 3'h0) ? 1'b0 : (hit_q || cnt_q == 5'h06);
        end
    end
endmodule // isr_bus_model
`default_nettype wire

// File: bench/test_isr_seq.sv
/* Self-checking bench for the stop and repeated-start sequencer.
   Assumes a bus model with pull-ups stands on the far side of the pins. */
`default_nettype none
module test_isr_seq;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ninth = 1'b0, stop = 1'b0, rstrt = 1'b0, wr = 1'b0, clr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [2:0] mode = 3'h0;
    logic scl, sda, scl_oe, sda_oe, en, pdet, irq, wr_col, bcol, rel;
    logic scl_d, sda_d;
    logic [7:0] sbuf;
    logic [10:0] r;
    int n_errors = 0;
    int num_checks = 0;
    // Each row: repeated start, bus mode, then expected en, stop, irq, bus coll, write coll, sda_oe, scl_oe.
    logic [10:0] rows [6] = '{11'h034, 11'h1B4, 11'h403, 11'h488, 11'h508, 11'h600};
    always #4 clk_i = ~clk_i;
    isr_seq dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .baud_reload_value_i(8'h10), .ninth_fall_i(ninth),
        .stop_start_i(stop), .rstart_start_i(rstrt), .buf_wr_i(wr), .buf_wdata_i(wdata),
        .flags_clr_i(clr), .scl_i(scl), .sda_i(sda), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_o(sda_d),
        .sda_oe_o(sda_oe), .stop_seq_enable_o(en), .stop_detected_o(pdet), .port_irq_flag_o(irq),
        .write_collision_o(wr_col), .bus_collision_o(bcol), .shift_buffer_o(sbuf));
    isr_bus_model bus (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_i(mode), .scl_oe_i(scl_oe),
        .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task pulse(input int w);
        @(negedge clk_i);
        {ninth, stop, rstrt, wr, clr} = 5'(1 << w);
        @(negedge clk_i);
        {ninth, stop, rstrt, wr, clr} = 5'h00;
    endtask
    task finish_test;
        $display("TB: checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #80000;
        n_errors++;
        finish_test;
    end
    initial
    begin
        repeat (6) @(negedge clk_i);
        check({1'b0, en, pdet, irq, bcol, wr_col, sda_oe, scl_oe}, 8'h00);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        wdata = 8'h3C;
        pulse(1);
        @(negedge clk_i);
        check(sbuf, 8'h3C);
        check({7'h00, wr_col}, 8'h00);
        $display("TB: reset and idle write done");
        foreach (rows[i])
        begin
            r = rows[i];
            pulse(4);
            @(negedge clk_i);
            check({7'h00, scl_oe}, 8'h01);
            mode = r[9:7];
            rel = 1'b0;
            pulse(r[10] ? 2 : 3);
            if (!r[10])
            begin
                @(negedge clk_i);
                check({6'h00, en, sda_oe}, 8'h03);
                wdata = 8'hA5;
                pulse(1);
            end
            for (int k = 0; k < 300; k++)
            begin
                @(negedge clk_i);
                rel = rel || !scl_oe;
                if (r[10] ? (bcol || (rel && scl_oe)) : irq)
                    break;
            end
            check({1'b0, en, pdet, irq, bcol, wr_col, sda_oe, scl_oe}, {1'b0, r[6:0]});
            check(sbuf, 8'h3C);
            check({6'h00, scl_d, sda_d}, 8'h00);
            mode = 3'h0;
            pulse(0);
            repeat (20) @(negedge clk_i);
            $display("TB: row %0d done", i);
        end
        pulse(3);
        repeat (4) @(negedge clk_i);
        check({6'h00, en, sda_oe}, 8'h00);
        pulse(4);
        pulse(3);
        repeat (3) @(negedge clk_i);
        rst_b_i = 1'b0;
        @(negedge clk_i);
        check({1'b0, en, pdet, irq, bcol, wr_col, sda_oe, scl_oe}, 8'h00);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        pulse(4);
        @(negedge clk_i);
        check({6'h00, sda_oe, scl_oe}, 8'h01);
        $display("TB: refusal and mid-run reset done");
        finish_test;
    end
endmodule // test_isr_seq
`default_nettype wire
